// >>> design/sdram_module_pkg.sv
// Package: command codes, field positions, mode layout and carrier types of the module interface
`default_nettype none
package sdram_module_pkg;
	// Geometry
	localparam int DATA_WIDTH = 64;
	localparam int BYTE_COUNT = 8;
	localparam int ADDR_WIDTH = 12;
	localparam int BANK_COUNT = 4;
	localparam int COL_WIDTH = 9;
	localparam int MEM_ROWS_USED = 4;
	// Address field positions
	localparam int PRECHARGE_ALL_BIT = 10;
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_BT_BIT = 3;
	localparam int MODE_CL_LSB = 4;
	localparam int MODE_WB_BIT = 9;
	// Reset values
	localparam logic [11:0] MODE_RESET = 12'h022;
	// Burst length codes
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	// Mask-to-high-Z latency in clocks
	localparam int MASK_LATENCY = 2;
	// Timing: self-timed auto precharge recovery
	localparam int AUTO_PRE_NS = 20;
	localparam int CLK_PERIOD_NS = 20;
	localparam int AUTO_PRE_CYCLES =
		(AUTO_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Command code {select_n, row_strobe_n, col_strobe_n, write_n}
	localparam logic [3:0] CMD_DESELECT = 4'h8;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVATE = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_TERMINATE = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	// Command bus as sampled at a clock edge
	typedef struct packed {
		logic select_n;
		logic row_strobe_n;
		logic col_strobe_n;
		logic write_n;
		logic [1:0] bank_select;
		logic [11:0] address_bus;
		logic [7:0] byte_mask;
	} cmd_bus_t;
	// Word moving through the read FIFO
	typedef struct packed {
		logic [7:0] byte_mask;
		logic [63:0] data;
	} read_word_t;
endpackage
`default_nettype wire

// >>> design/sdram_fifo.sv
// Parameterised valid/ready FIFO used in the read data path
`default_nettype none
module sdram_fifo #(
	parameter int WIDTH = 72,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW-1:0] wr_ptr; // Write index
	logic [AW-1:0] rd_ptr; // Read index
	logic [AW:0] count; // Occupancy
	logic push;
	logic pop;
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage write
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
	// Pointers and count
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule
`default_nettype wire

// >>> design/sdram_module.sv
// Device side of a 64-bit SDRAM module: command decode, banks, bursts, data pins
// Overview of operation
// - Strobes plus chip select form the command
// - All inputs sampled on rising clock edge
// - Burst counter and outputs advance each active edge
// - Clock active while clock enable high
// - Enable low picks power-down, self refresh, suspend
// - Enable synchronous except inside power-down modes; here it passes the same synchroniser and filter in every state
// - Ignore bus during power-down and self refresh
// - Select high masks all commands
// - Masked write bytes leave storage unchanged
// - Read mask gives high-Z two clocks later
// - Bank select picks bank for commands
// - Address carries row, column, auto precharge flag
// - Precharge flag high closes all banks
// - Mode register loaded from address bus
// - Start column from nine low address bits
// - Burst lengths 1,2,4,8,page; early terminate
// - Auto precharge starts after burst completes
`default_nettype none
module sdram_module #(
	parameter int MEM_WORDS = 2048, // Modelled words (bank x row x column, folded)
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Command pins
	input wire logic rank_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_n,
	input wire logic rank_clock_enable,
	input wire logic [1:0] bank_select,
	input wire logic [11:0] address_bus,
	input wire logic [7:0] byte_mask,
	// Data pins
	input wire logic [63:0] data_bus_in,
	output logic [63:0] data_bus_out,
	output logic [7:0] data_bus_oe,
	// Status
	output logic [3:0] bank_open,
	output logic [11:0] mode_word,
	output logic power_down,
	output logic self_refresh,
	output logic clock_suspend
);
	localparam int MAW = $clog2(MEM_WORDS);
	typedef enum {ST_IDLE, ST_READ, ST_WRITE} burst_state_t;
	typedef enum {PM_RUN, PM_PRE_PD, PM_ACT_PD, PM_SELF_REF, PM_SUSPEND} power_state_t;

	sdram_module_pkg::cmd_bus_t cmd; // Registered command bus
	logic [3:0] code; // Decoded command code
	logic cke_s1, cke_s2, cke_s3; // Clock enable synchroniser
	logic cke_prev; // Filtered enable level, updated at any edge where the last two synchroniser flops agree
	logic active; // Clock counts as active this edge
	burst_state_t burst_state;
	power_state_t power_state;
	logic [11:0] open_row [4]; // Open row per bank
	logic [11:0] mode_reg;
	logic [8:0] col; // Burst column counter
	logic [8:0] beats_left;
	logic [1:0] burst_bank;
	logic burst_auto_pre;
	logic [63:0] mem [MEM_WORDS];
	logic [MAW-1:0] word_addr;
	logic [7:0] mask_d1, mask_d2; // Read mask pipeline
	logic [3:0] pre_timer [4]; // Self-timed precharge per bank
	logic [3:0] pre_pending;
	logic [8:0] burst_len;
	sdram_module_pkg::read_word_t fifo_in, fifo_out;
	logic fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [2:0] refresh_seen; // Refresh decodes, delayed to line up with the filtered enable

	// Clock enable comes from the pin: three flops, change taken when the last two agree
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cke_s1 <= 1'b1;
			cke_s2 <= 1'b1;
			cke_s3 <= 1'b1;
		end else begin
			cke_s1 <= rank_clock_enable;
			cke_s2 <= cke_s1;
			cke_s3 <= cke_s2;
		end
	end

	// Filtered enable level
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cke_prev <= 1'b1;
		end else if (cke_s2 == cke_s3) begin
			cke_prev <= cke_s3;
		end
	end
	assign active = cke_prev;

	// Register the command bus on each rising edge
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cmd <= '{select_n: 1'b1, row_strobe_n: 1'b1, col_strobe_n: 1'b1,
				write_n: 1'b1, bank_select: 2'h0, address_bus: 12'h000, byte_mask: 8'h00};
		end else begin
			cmd <= '{select_n: rank_select_n, row_strobe_n: row_strobe_n,
				col_strobe_n: col_strobe_n, write_n: write_n, bank_select: bank_select,
				address_bus: address_bus, byte_mask: byte_mask};
		end
	end

	// Command decode: select high masks everything; inputs ignored when not running
	always_comb begin
		if (!active || power_state != PM_RUN) begin
			code = sdram_module_pkg::CMD_NOP;
		end else if (cmd.select_n) begin
			code = sdram_module_pkg::CMD_DESELECT;
		end else begin
			code = {1'b0, cmd.row_strobe_n, cmd.col_strobe_n, cmd.write_n};
		end
	end

	// Burst length from the mode word
	always_comb begin
		case (mode_reg[2:0])
			sdram_module_pkg::BL_1: burst_len = 9'h001;
			sdram_module_pkg::BL_2: burst_len = 9'h002;
			sdram_module_pkg::BL_4: burst_len = 9'h004;
			sdram_module_pkg::BL_8: burst_len = 9'h008;
			default: burst_len = 9'h000; // Full page: runs until terminated
		endcase
	end

	// Refresh history: the enable filter lags the command register by three edges,
	// so a refresh given with enable low is remembered until the drop is seen
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			refresh_seen <= 3'h0;
		end else begin
			refresh_seen <= {refresh_seen[1:0], code == sdram_module_pkg::CMD_REFRESH};
		end
	end

	// Power state: chosen from activity when enable drops
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			power_state <= PM_RUN;
		end else begin
			case (power_state)
				PM_RUN: begin
					if (!cke_prev) begin
						if (burst_state != ST_IDLE) begin
							power_state <= PM_SUSPEND;
						end else if (bank_open != 4'h0) begin
							power_state <= PM_ACT_PD;
						end else if (refresh_seen[2]) begin
							power_state <= PM_SELF_REF;
						end else begin
							power_state <= PM_PRE_PD;
						end
					end
				end
				default: begin
					if (cke_prev) begin
						power_state <= PM_RUN;
					end
				end
			endcase
		end
	end
	assign power_down = (power_state == PM_PRE_PD) || (power_state == PM_ACT_PD);
	assign self_refresh = (power_state == PM_SELF_REF);
	assign clock_suspend = (power_state == PM_SUSPEND);

	// Mode register
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_reg <= sdram_module_pkg::MODE_RESET;
		end else if (code == sdram_module_pkg::CMD_MRS && burst_state == ST_IDLE) begin
			mode_reg <= cmd.address_bus;
		end
	end
	assign mode_word = mode_reg;

	// Bank open/close, including auto precharge timers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bank_open <= 4'h0;
			pre_pending <= 4'h0;
			for (int b = 0; b < 4; b++) begin
				open_row[b] <= 12'h000;
				pre_timer[b] <= 4'h0;
			end
		end else begin
			for (int b = 0; b < 4; b++) begin
				if (pre_pending[b]) begin
					if (pre_timer[b] == 4'h0) begin
						bank_open[b] <= 1'b0;
						pre_pending[b] <= 1'b0;
					end else begin
						pre_timer[b] <= pre_timer[b] - 4'h1;
					end
				end
			end
			if (code == sdram_module_pkg::CMD_ACTIVATE) begin
				bank_open[cmd.bank_select] <= 1'b1;
				open_row[cmd.bank_select] <= cmd.address_bus;
			end else if (code == sdram_module_pkg::CMD_PRECHARGE) begin
				if (cmd.address_bus[sdram_module_pkg::PRECHARGE_ALL_BIT]) begin
					bank_open <= 4'h0;
				end else begin
					bank_open[cmd.bank_select] <= 1'b0;
				end
			end
			if (active && burst_state != ST_IDLE && burst_auto_pre && beats_left == 9'h001) begin
				pre_pending[burst_bank] <= 1'b1;
				pre_timer[burst_bank] <= 4'(sdram_module_pkg::AUTO_PRE_CYCLES - 1);
			end
		end
	end

	// Burst sequencer: start, count, terminate, interrupt by new access
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			burst_state <= ST_IDLE;
			col <= 9'h000;
			beats_left <= 9'h000;
			burst_bank <= 2'h0;
			burst_auto_pre <= 1'b0;
		end else if (code == sdram_module_pkg::CMD_READ || code == sdram_module_pkg::CMD_WRITE) begin
			// an access to a closed bank is not started
			if (bank_open[cmd.bank_select]) begin
				burst_state <= (code == sdram_module_pkg::CMD_READ) ? ST_READ : ST_WRITE;
				col <= cmd.address_bus[8:0];
				beats_left <= burst_len;
				burst_bank <= cmd.bank_select;
				burst_auto_pre <= cmd.address_bus[sdram_module_pkg::PRECHARGE_ALL_BIT];
			end
		end else if (code == sdram_module_pkg::CMD_TERMINATE) begin
			burst_state <= ST_IDLE;
		end else if (active && burst_state != ST_IDLE) begin
			col <= col + 9'h001;
			if (beats_left == 9'h001) begin
				burst_state <= ST_IDLE;
			end
			if (beats_left != 9'h000) begin
				beats_left <= beats_left - 9'h001;
			end
		end
	end

	// Folded memory word address
	assign word_addr = MAW'({burst_bank, open_row[burst_bank], col});

	// Write with byte masks
	generate
		for (genvar i = 0; i < 8; i++) begin : g_byte
			always_ff @(posedge clk) begin
				if (active && burst_state == ST_WRITE && !cmd.byte_mask[i]) begin
					mem[word_addr][8*i +: 8] <= data_bus_in[8*i +: 8];
				end
			end
		end
	endgenerate

	// Read mask pipeline: mask sampled now acts two clocks later
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mask_d1 <= 8'hFF;
			mask_d2 <= 8'hFF;
		end else if (active) begin
			mask_d1 <= cmd.byte_mask;
			mask_d2 <= mask_d1;
		end
	end

	// Read word enters FIFO; suspend stalls the drain
	assign fifo_in = '{byte_mask: mask_d2, data: mem[word_addr]};
	assign fifo_pop = active && fifo_out_valid;
	sdram_fifo #(
		.WIDTH(72),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(active && burst_state == ST_READ && fifo_in_ready),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out)
	);

	// Output registers on the data pins
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			data_bus_out <= 64'h0000000000000000;
			data_bus_oe <= 8'h00;
		end else if (active) begin
			if (fifo_pop) begin
				data_bus_out <= fifo_out.data;
				// Mask registered with the command reaches the pins two edges on
				data_bus_oe <= ~mask_d1;
			end else begin
				data_bus_oe <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/sdram_module_properties.sv
// Pin-level checks of the SDRAM module device side
`default_nettype none
module sdram_module_properties (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Command pins
	input wire logic rank_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_n,
	input wire logic rank_clock_enable,
	input wire logic [1:0] bank_select,
	input wire logic [11:0] address_bus,
	input wire logic [7:0] byte_mask,
	// Data pins
	input wire logic [63:0] data_bus_in,
	input wire logic [63:0] data_bus_out,
	input wire logic [7:0] data_bus_oe,
	// Status
	input wire logic [3:0] bank_open,
	input wire logic [11:0] mode_word,
	input wire logic power_down,
	input wire logic self_refresh,
	input wire logic clock_suspend
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cmd; // Command code on the pins
	logic [2:0] run; // Edges with clock enable high, saturating
	logic idle; // No power or suspend state
	assign cmd = {rank_select_n, row_strobe_n, col_strobe_n, write_n};
	assign idle = !(power_down || self_refresh || clock_suspend);
	// Counts edges of steady clock enable, so the enable filter has settled
	always_ff @(posedge clk) begin
		if (!rst_b || !rank_clock_enable) begin
			run <= 3'h0;
		end else if (run != 3'h7) begin
			run <= run + 3'h1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// A command the device must act on
	sequence s_live(c);
		cmd == c && run == 3'h7 && idle;
	endsequence
	property p_reset;
		$rose(rst_b) |-> mode_word == sdram_module_pkg::MODE_RESET && bank_open == 4'h0
			&& data_bus_oe == 8'h00 && idle;
	endproperty
	a_reset: assert property (p_reset) else $error("reset values wrong");
	property p_open;
		(bank_open & ~$past(bank_open)) != 4'h0 |-> $past(cmd, 2) == sdram_module_pkg::CMD_ACTIVATE
			&& (bank_open & ~$past(bank_open)) == 4'h1 << $past(bank_select, 2);
	endproperty
	a_open: assert property (p_open) else $error("bank opened without activate");
	property p_pre_all;
		s_live(sdram_module_pkg::CMD_PRECHARGE) ##0 address_bus[10] |-> ##2 bank_open == 4'h0;
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("banks left open");
	property p_pre_one;
		s_live(sdram_module_pkg::CMD_PRECHARGE) ##0 !address_bus[10]
			|-> ##2 !bank_open[$past(bank_select, 2)];
	endproperty
	a_pre_one: assert property (p_pre_one) else $error("bank left open");
	property p_mode;
		$changed(mode_word) && $past(rst_b) |-> $past(cmd, 2) == sdram_module_pkg::CMD_MRS
			&& mode_word == $past(address_bus, 2);
	endproperty
	a_mode: assert property (p_mode) else $error("mode word changed wrongly");
	property p_mask;
		data_bus_oe != 8'h00 |-> (data_bus_oe & $past(byte_mask, 3)) == 8'h00;
	endproperty
	a_mask: assert property (p_mask) else $error("masked byte driven");
	property p_enter;
		$rose(!idle) |-> run < 3'h6;
	endproperty
	a_enter: assert property (p_enter) else $error("power state with enable high");
	property p_exit;
		run == 3'h7 |-> idle;
	endproperty
	a_exit: assert property (p_exit) else $error("power state not left");
endmodule
`default_nettype wire

// >>> tb/sdram_host.sv
// Host controller model: command pins, clock enable and its side of the data pins
`default_nettype none
module sdram_host (
	// Clock
	input wire logic clk,
	// Device data pins
	input wire logic [63:0] data_bus_out,
	input wire logic [7:0] data_bus_oe,
	// Command pins
	output var sdram_module_pkg::cmd_bus_t pins,
	output logic cke,
	// Wire level of the data pins
	output logic [63:0] data_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] wdata; // Value the host drives
	logic drive; // Host drives the data pins
	// Released bytes show the inverse of the host value, never a stale copy
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			data_bus[8*i+:8] = data_bus_oe[i] ? data_bus_out[8*i+:8]
				: (drive ? wdata[8*i+:8] : ~wdata[8*i+:8]);
		end
	end
	initial begin
		pins = {sdram_module_pkg::CMD_NOP, 22'h0};
		cke = 1'b1;
		wdata = 64'h0;
		drive = 1'b0;
	end
	// One command at the next edge, then a no-operation
	task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic en);
		@(posedge clk);
		pins[25:22] <= c;
		pins.bank_select <= b;
		pins.address_bus <= a;
		cke <= en;
		@(posedge clk);
		pins[25:22] <= sdram_module_pkg::CMD_NOP;
	endtask
	// Data and mask held from the next edge on
	task automatic put(input logic [63:0] d, input logic [7:0] m, input logic dr);
		@(posedge clk);
		wdata <= d;
		pins.byte_mask <= m;
		drive <= dr;
	endtask
	// Waits a bounded time for a driven beat
	task automatic fetch(output logic [63:0] d, output logic [7:0] oe);
		oe = 8'h00;
		d = 64'h0;
		for (int n = 0; n < 12 && oe == 8'h00; n++) begin
			@(posedge clk);
			#1;
			oe = data_bus_oe;
			d = data_bus;
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench of the SDRAM module device side
`default_nettype none
bind sdram_module sdram_module_properties i_props (.clk, .rst_b, .rank_select_n, .row_strobe_n,
	.col_strobe_n, .write_n, .rank_clock_enable, .bank_select, .address_bus, .byte_mask,
	.data_bus_in, .data_bus_out, .data_bus_oe, .bank_open, .mode_word, .power_down,
	.self_refresh, .clock_suspend);
`define CHECK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %0t got %h expected %h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [1:0] bank; logic [8:0] col; logic [7:0] mask;
		logic [1:0] close;} row_t;
	logic clk, rst_b, cke, power_down, self_refresh, clock_suspend; // Clock, reset, status
	sdram_module_pkg::cmd_bus_t pins; // Command pins from the host
	logic [63:0] data_bus, data_bus_out, a, d; // Data pins and values
	logic [7:0] data_bus_oe, oe; // Byte enables
	logic [3:0] bank_open; // Open banks
	logic [11:0] mode_word; // Mode register
	row_t rows [4]; // Ordinary cases
	int bad_count = 0, total_checks = 0, cycles = 0, pushed;
	sdram_module i_sdram_module (.clk, .rst_b, .rank_select_n(pins.select_n),
		.row_strobe_n(pins.row_strobe_n), .col_strobe_n(pins.col_strobe_n),
		.write_n(pins.write_n), .rank_clock_enable(cke), .bank_select(pins.bank_select),
		.address_bus(pins.address_bus), .byte_mask(pins.byte_mask), .data_bus_in(data_bus),
		.data_bus_out, .data_bus_oe, .bank_open, .mode_word, .power_down, .self_refresh,
		.clock_suspend);
	sdram_host i_sdram_host (.clk, .data_bus_out, .data_bus_oe, .pins, .cke, .data_bus);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			$display("[ERR] %0t timeout", $time);
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (bad_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Byte mask spread over bit lanes
	function automatic logic [63:0] lanes(input logic [7:0] m);
		for (int i = 0; i < 8; i++) lanes[8*i+:8] = {8{m[i]}};
	endfunction
	// Lets edges pass, then samples settled outputs
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Write one burst with data and mask held around the command
	task automatic wr(input logic [1:0] b, input logic [8:0] c, input logic [63:0] v,
		input logic [7:0] m);
		i_sdram_host.put(v, m, 1'b1);
		i_sdram_host.issue(sdram_module_pkg::CMD_WRITE, b, {3'h0, c}, 1'b1);
		settle(3);
	endtask
	initial begin
		rst_b = 1'b0;
		rows = '{'{2'h0, 9'h000, 8'h00, 2'h0}, '{2'h1, 9'h1FF, 8'h0F, 2'h1},
			'{2'h2, 9'h055, 8'hA5, 2'h2}, '{2'h3, 9'h100, 8'hFF, 2'h0}};
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		settle(1);
		`CHECK({mode_word, bank_open, data_bus_oe}, {sdram_module_pkg::MODE_RESET, 12'h000})
		`CHECK({power_down, self_refresh, clock_suspend}, 3'h0)
		i_sdram_host.issue(sdram_module_pkg::CMD_MRS, 2'h0, 12'h020, 1'b1);
		settle(2);
		`CHECK(mode_word, 12'h020)
		// Each row: open, write, masked overwrite, read back, close
		foreach (rows[i]) begin
			a = 64'h0F1E_2D3C_4B5A_6978 + 64'(i);
			i_sdram_host.issue(sdram_module_pkg::CMD_ACTIVATE, rows[i].bank, 12'h001, 1'b1);
			wr(rows[i].bank, rows[i].col, a, 8'h00);
			wr(rows[i].bank, rows[i].col, ~a, rows[i].mask);
			i_sdram_host.put(64'h0, 8'h00, 1'b0);
			i_sdram_host.issue(sdram_module_pkg::CMD_READ, rows[i].bank,
				{1'b0, rows[i].close == 2'h2, 1'b0, rows[i].col}, 1'b1);
			i_sdram_host.fetch(d, oe);
			`CHECK(oe, 8'hFF)
			`CHECK(d, (a & lanes(rows[i].mask)) | (~a & ~lanes(rows[i].mask)))
			if (rows[i].close != 2'h2) i_sdram_host.issue(sdram_module_pkg::CMD_PRECHARGE,
				rows[i].bank, {1'b0, rows[i].close[0], 10'h000}, 1'b1);
			settle(4);
			`CHECK(bank_open, 4'h0)
		end
		// Deselected activate is ignored
		i_sdram_host.issue(sdram_module_pkg::CMD_ACTIVATE | 4'h8, 2'h0, 12'h000, 1'b1);
		settle(3);
		`CHECK(bank_open, 4'h0)
		// Masked read, then one-bank and all-bank precharge
		i_sdram_host.issue(sdram_module_pkg::CMD_ACTIVATE, 2'h1, 12'h002, 1'b1);
		i_sdram_host.issue(sdram_module_pkg::CMD_ACTIVATE, 2'h2, 12'h002, 1'b1);
		i_sdram_host.put(64'h0, 8'hF0, 1'b0);
		i_sdram_host.issue(sdram_module_pkg::CMD_READ, 2'h1, 12'h000, 1'b1);
		i_sdram_host.fetch(d, oe);
		`CHECK(oe, 8'h0F)
		i_sdram_host.issue(sdram_module_pkg::CMD_PRECHARGE, 2'h2, 12'h000, 1'b1);
		settle(2);
		`CHECK(bank_open, 4'h2)
		i_sdram_host.issue(sdram_module_pkg::CMD_PRECHARGE, 2'h0, 12'h400, 1'b1);
		settle(2);
		`CHECK(bank_open, 4'h0)
		// Power-down, ignored activate, exit, then self refresh
		i_sdram_host.issue(sdram_module_pkg::CMD_NOP, 2'h0, 12'h000, 1'b0);
		settle(6);
		`CHECK(power_down, 1'b1)
		i_sdram_host.issue(sdram_module_pkg::CMD_ACTIVATE, 2'h3, 12'h000, 1'b0);
		settle(3);
		`CHECK(bank_open, 4'h0)
		i_sdram_host.issue(sdram_module_pkg::CMD_NOP, 2'h0, 12'h000, 1'b1);
		settle(8);
		`CHECK(power_down, 1'b0)
		i_sdram_host.issue(sdram_module_pkg::CMD_REFRESH, 2'h0, 12'h000, 1'b0);
		settle(6);
		`CHECK(self_refresh, 1'b1)
		i_sdram_host.issue(sdram_module_pkg::CMD_NOP, 2'h0, 12'h000, 1'b1);
		settle(8);
		`CHECK(self_refresh, 1'b0)
		// Eight-beat burst written, then read back through the read buffer
		i_sdram_host.issue(sdram_module_pkg::CMD_MRS, 2'h0, 12'h023, 1'b1);
		settle(2);
		`CHECK(mode_word, 12'h023)
		i_sdram_host.issue(sdram_module_pkg::CMD_ACTIVATE, 2'h0, 12'h001, 1'b1);
		wr(2'h0, 9'h000, a, 8'h00);
		settle(8);
		i_sdram_host.put(64'h0, 8'h00, 1'b0);
		i_sdram_host.issue(sdram_module_pkg::CMD_READ, 2'h0, 12'h000, 1'b1);
		pushed = 0;
		for (int n = 0; n < 16; n++) begin
			settle(1);
			if (data_bus_oe === 8'hFF) begin `CHECK(data_bus_out, a) pushed++; end
		end
		`CHECK(pushed, 8)
		give_verdict();
	end
endmodule
`default_nettype wire
